// ===== verilog/fault_summary_defs.svh
// Register indices, field positions and reset values of the status group.
// Assumes the byte address on the bus is four times the register index.
`ifndef FAULT_SUMMARY_DEFS_SVH
`define FAULT_SUMMARY_DEFS_SVH

// ---------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------
`define IDX_GLOBAL_ALARM_SUMMARY  16'hB018
`define IDX_NET_AW1_SUMMARY       16'hB019
`define IDX_NET_FAULT_SUMMARY     16'hB01A
`define IDX_HOST_FAULT_SUMMARY    16'hB01B
`define IDX_RESERVED_WORD         16'hB01C
`define IDX_GENERAL_STATUS        16'hB01D
`define IDX_FATAL_FAULT_STATUS    16'hB01E
`define IDX_ALARM_WARNING_GROUP1  16'hB01F
`define IDX_GENERAL_STATUS_LATCH  16'hB023
`define IDX_GENERAL_STATUS_ENABLE 16'hB029

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define GS_COOLING_BIT   13
`define GS_REFERENCE_CLOCK_INPUT_BIT    10
`define GS_JITTER_BIT    9
`define GS_CMU_BIT       8
`define GS_TXLOSF_BIT    7
`define GS_HOSTLOL_BIT   6
`define GS_RXLOS_BIT     5
`define GS_RXLOL_BIT     4
`define GS_ALIGN_BIT     3
`define GS_PMDONE_BIT    2
`define GS_HIPWR_BIT     1
`define FF_PLD_BIT       6
`define FF_SUPPLY_BIT    5
`define FF_CHECKSUM_BIT  1
`define GA_GENSTAT_BIT   8
`define GA_STATE_BIT     7
`define GA_NETAW2_BIT    6
`define GA_NETHOST_BIT   5
`define GA_EXT_BIT       4
`define GA_VENDOR_BIT    3
`define GA_SOFTTEST_BIT  0
`define MODULE_FAULT_STATE 16'h0040

// ---------------------------------------------------------------
// Reset values and masks
// ---------------------------------------------------------------
`define GS_ENABLE_RESET  16'hA7F8
`define GS_ENABLE_WMASK  16'hA7FC
`define GS_CHANGE_MASK   16'h00F0
`define GS_LEVEL_MASK    16'h270C

`endif

// ===== verilog/fault_summary_pkg.sv
// Types shared by the status and summary register group.
// Assumes the constants header is compiled alongside.
package fault_summary_pkg;

  typedef logic [15:0] word_t;
  typedef logic [31:0] bus_word_t;

endpackage : fault_summary_pkg

// ===== verilog/module_fault_alarm_status_summary.sv
// Status, fault and summary register group of a transceiver module.
// Assumes per-lane latch/enable words and status come from same-clock logic.
`timescale 1ns/1ps
`include "fault_summary_defs.svh"

module module_fault_alarm_status_summary #(
  parameter int NUM_LANES = 16
) (
  input  wire logic                          clk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic [17:0]                   avs_address_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  input  wire logic [31:0]                   avs_writedata_in,
  input  wire logic [3:0]                    avs_byteenable_in,
  input  wire logic [8:0]                    module_state_in,
  input  wire logic [8:0]                    state_latch_in,
  input  wire logic [8:0]                    state_enable_in,
  input  wire logic [15:0]                   net_aw2_summary_in,
  input  wire logic [15:0]                   net_aw2_enable_in,
  input  wire logic [15:0]                   nethost_summary_in,
  input  wire logic [15:0]                   nethost_enable_in,
  input  wire logic [15:0]                   ext_latch_in,
  input  wire logic [15:0]                   ext_enable_in,
  input  wire logic [15:0]                   vendor_latch_in,
  input  wire logic [15:0]                   vendor_enable_in,
  input  wire logic                          soft_alarm_test_in,
  input  wire logic [NUM_LANES*16-1:0]       net_aw_latch_in,
  input  wire logic [NUM_LANES*16-1:0]       net_aw_enable_in,
  input  wire logic [NUM_LANES*16-1:0]       net_fault_latch_in,
  input  wire logic [NUM_LANES*16-1:0]       net_fault_enable_in,
  input  wire logic [NUM_LANES*16-1:0]       host_fault_latch_in,
  input  wire logic [NUM_LANES*16-1:0]       host_fault_enable_in,
  input  wire logic                          cooling_overload_flag_in,
  input  wire logic                          interlock_used_in,
  input  wire logic                          reference_clock_loss_in,
  input  wire logic                          tx_jitter_loop_unlock_in,
  input  wire logic                          tx_clock_multiplier_unlock_in,
  input  wire logic [NUM_LANES-1:0]          tx_functionality_loss_in,
  input  wire logic [NUM_LANES-1:0]          tx_host_side_unlock_in,
  input  wire logic [NUM_LANES-1:0]          rx_signal_loss_in,
  input  wire logic [NUM_LANES-1:0]          rx_network_side_unlock_in,
  input  wire logic                          out_of_alignment_in,
  input  wire logic                          pm_interval_done_in,
  input  wire logic                          high_power_active_in,
  input  wire logic                          pld_init_fault_in,
  input  wire logic                          supply_fault_in,
  input  wire logic                          checksum_fault_in,
  input  wire logic [3:0]                    temp_flags_in,
  input  wire logic [3:0]                    vcc_flags_in,
  input  wire logic [3:0]                    optical_amplifier_flags_in,
  output logic [31:0]                        avs_readdata_out,
  output logic                               avs_waitrequest_out,
  output logic [15:0]                        module_state_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic or_enabled(
    input logic [15:0] latch,
    input logic [15:0] enable
  );
    or_enabled = |(latch & enable);
  endfunction : or_enabled

  fault_summary_pkg::word_t net_aw1_sum;
  fault_summary_pkg::word_t net_fault_sum;
  fault_summary_pkg::word_t host_fault_sum;
  fault_summary_pkg::word_t global_sum;
  fault_summary_pkg::word_t gen_status;
  fault_summary_pkg::word_t fatal_status;
  fault_summary_pkg::word_t aw_group1;
  fault_summary_pkg::word_t gs_latch_q;
  fault_summary_pkg::word_t gs_prev_q;
  fault_summary_pkg::word_t gs_enable_q;
  fault_summary_pkg::word_t gs_set;
  fault_summary_pkg::word_t rd_word;
  logic [15:0]              reg_index;
  logic                     waitreq_q;
  logic                     req;
  logic                     accept;
  logic                     fatal_any;
  logic                     gs_summary;
  localparam logic [15:0]   enable_wmask = `GS_ENABLE_WMASK;

  // ---------------------------------------------------------------
  // Per-lane summaries
  // ---------------------------------------------------------------
  always_comb
  begin
    net_aw1_sum    = '0;
    net_fault_sum  = '0;
    host_fault_sum = '0;
    for (int n = 0; n < NUM_LANES; n++)
    begin
      net_aw1_sum[n]    = or_enabled(net_aw_latch_in[n*16 +: 16],
                                     net_aw_enable_in[n*16 +: 16]);
      net_fault_sum[n]  = or_enabled(net_fault_latch_in[n*16 +: 16],
                                     net_fault_enable_in[n*16 +: 16]);
      host_fault_sum[n] = or_enabled(host_fault_latch_in[n*16 +: 16],
                                     host_fault_enable_in[n*16 +: 16]);
    end
  end

  // ---------------------------------------------------------------
  // Live status words
  // ---------------------------------------------------------------
  always_comb
  begin
    gen_status = '0;
    gen_status[`GS_COOLING_BIT] = cooling_overload_flag_in
                                  & interlock_used_in;
    gen_status[`GS_REFERENCE_CLOCK_INPUT_BIT]  = reference_clock_loss_in;
    gen_status[`GS_JITTER_BIT]  = tx_jitter_loop_unlock_in;
    gen_status[`GS_CMU_BIT]     = tx_clock_multiplier_unlock_in;
    gen_status[`GS_TXLOSF_BIT]  = |tx_functionality_loss_in;
    gen_status[`GS_HOSTLOL_BIT] = |tx_host_side_unlock_in;
    gen_status[`GS_RXLOS_BIT]   = |rx_signal_loss_in;
    gen_status[`GS_RXLOL_BIT]   = |rx_network_side_unlock_in;
    gen_status[`GS_ALIGN_BIT]   = out_of_alignment_in;
    gen_status[`GS_PMDONE_BIT]  = pm_interval_done_in;
    gen_status[`GS_HIPWR_BIT]   = high_power_active_in;
  end

  always_comb
  begin
    fatal_status = '0;
    fatal_status[`FF_PLD_BIT]      = pld_init_fault_in;
    fatal_status[`FF_SUPPLY_BIT]   = supply_fault_in;
    fatal_status[`FF_CHECKSUM_BIT] = checksum_fault_in;
  end

  assign fatal_any = |fatal_status;
  assign aw_group1 = {4'h0, temp_flags_in, vcc_flags_in,
                      optical_amplifier_flags_in};

  // ---------------------------------------------------------------
  // General status latch and enable
  // ---------------------------------------------------------------
  assign gs_set = ((gen_status ^ gs_prev_q) & `GS_CHANGE_MASK)
                | (gen_status & `GS_LEVEL_MASK);
  assign gs_summary = or_enabled(gs_latch_q,
                                 {1'b0, gs_enable_q[14:0]});

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      gs_prev_q <= 16'h0000;
    else
      gs_prev_q <= gen_status;
  end

  // Clear only bits the read returned; set wins
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      gs_latch_q <= 16'h0000;
    else if (accept && avs_read_in
             && reg_index == `IDX_GENERAL_STATUS_LATCH)
      gs_latch_q <= (gs_latch_q & ~avs_readdata_out[15:0]) | gs_set;
    else
      gs_latch_q <= gs_latch_q | gs_set;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      gs_enable_q <= `GS_ENABLE_RESET;
    else if (accept && avs_write_in
             && reg_index == `IDX_GENERAL_STATUS_ENABLE)
    begin
      if (avs_byteenable_in[0])
        gs_enable_q[7:0] <= avs_writedata_in[7:0]
                          & enable_wmask[7:0];
      if (avs_byteenable_in[1])
        gs_enable_q[15:8] <= avs_writedata_in[15:8]
                           & enable_wmask[15:8];
    end
  end

  // ---------------------------------------------------------------
  // Global alarm summary
  // ---------------------------------------------------------------
  always_comb
  begin
    global_sum = '0;
    global_sum[`GA_GENSTAT_BIT]  = gs_summary;
    global_sum[`GA_STATE_BIT]    = |(state_latch_in & state_enable_in);
    global_sum[`GA_NETAW2_BIT]   = or_enabled(net_aw2_summary_in,
                                              net_aw2_enable_in);
    global_sum[`GA_NETHOST_BIT]  = or_enabled(nethost_summary_in,
                                              nethost_enable_in);
    global_sum[`GA_EXT_BIT]      = or_enabled(ext_latch_in,
                                              ext_enable_in);
    global_sum[`GA_VENDOR_BIT]   = or_enabled(vendor_latch_in,
                                              vendor_enable_in);
    global_sum[`GA_SOFTTEST_BIT] = soft_alarm_test_in;
  end

  // ---------------------------------------------------------------
  // Module state with fault override
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      module_state_out <= 16'h0000;
    else if (fatal_any)
      module_state_out <= `MODULE_FAULT_STATE;
    else
      module_state_out <= {7'h00, module_state_in};
  end

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  assign reg_index = avs_address_in[17:2];
  assign req       = avs_read_in | avs_write_in;
  assign accept    = req & ~waitreq_q;
  assign avs_waitrequest_out = waitreq_q;

  always_comb
  begin
    unique case (reg_index)
      `IDX_GLOBAL_ALARM_SUMMARY:  rd_word = global_sum;
      `IDX_NET_AW1_SUMMARY:       rd_word = net_aw1_sum;
      `IDX_NET_FAULT_SUMMARY:     rd_word = net_fault_sum;
      `IDX_HOST_FAULT_SUMMARY:    rd_word = host_fault_sum;
      `IDX_GENERAL_STATUS:        rd_word = gen_status;
      `IDX_FATAL_FAULT_STATUS:    rd_word = fatal_status;
      `IDX_ALARM_WARNING_GROUP1:  rd_word = aw_group1;
      `IDX_GENERAL_STATUS_LATCH:  rd_word = gs_latch_q;
      `IDX_GENERAL_STATUS_ENABLE: rd_word = gs_enable_q;
      default:                    rd_word = 16'h0000;
    endcase
  end

  // One wait cycle per request
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      waitreq_q <= 1'b1;
    else
      waitreq_q <= ~(req & waitreq_q);
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in && waitreq_q)
      avs_readdata_out <= {16'h0000, rd_word};
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic first_rd;
  assign first_rd = avs_read_in & waitreq_q;

  AST_GLOBAL_STATE: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (first_rd && reg_index == `IDX_GLOBAL_ALARM_SUMMARY) |=>
      avs_readdata_out[7] == $past(|(state_latch_in & state_enable_in)))
    else $error("global bit 7 wrong");

  AST_GLOBAL_NETAW2: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (first_rd && reg_index == `IDX_GLOBAL_ALARM_SUMMARY) |=>
      avs_readdata_out[6]
        == $past(|(net_aw2_summary_in & net_aw2_enable_in)))
    else $error("global bit 6 wrong");

  AST_GLOBAL_RSVD: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (first_rd && reg_index == `IDX_GLOBAL_ALARM_SUMMARY) |=>
      avs_readdata_out[2:1] == 2'b00
      && avs_readdata_out[0] == $past(soft_alarm_test_in))
    else $error("global bits 2..0 wrong");

  AST_NET_FAULT_LANE0: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (first_rd && reg_index == `IDX_NET_FAULT_SUMMARY) |=>
      avs_readdata_out[0]
        == $past(|(net_fault_latch_in[15:0] & net_fault_enable_in[15:0])))
    else $error("network fault lane 0 summary wrong");

  AST_FATAL_FORCES_STATE: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (pld_init_fault_in || supply_fault_in || checksum_fault_in) |=>
      module_state_out == `MODULE_FAULT_STATE)
    else $error("fault state not forced");

  AST_FATAL_RSVD: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (first_rd && reg_index == `IDX_FATAL_FAULT_STATUS) |=>
      (avs_readdata_out[15:0] & 16'hFF9D) == 16'h0000)
    else $error("fatal reserved bits set");

  AST_CHANGE_LATCH: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    $fell(|rx_signal_loss_in) |=> gs_latch_q[`GS_RXLOS_BIT])
    else $error("change latch missed a fall");

  AST_ENABLE_GATES: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (gs_enable_q[14:0] == 15'h0000) |-> !global_sum[`GA_GENSTAT_BIT])
    else $error("disabled latch reaches summary");

  AST_TXLOSF_OR: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (first_rd && reg_index == `IDX_GENERAL_STATUS) |=>
      avs_readdata_out[7] == $past(|tx_functionality_loss_in))
    else $error("transmit loss OR wrong");

  AST_NET_AW1_LANE0: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (first_rd && reg_index == `IDX_NET_AW1_SUMMARY) |=>
      avs_readdata_out[0]
        == $past(|(net_aw_latch_in[15:0] & net_aw_enable_in[15:0])))
    else $error("network group 1 lane 0 summary wrong");

  AST_HOST_FAULT_LANE0: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (first_rd && reg_index == `IDX_HOST_FAULT_SUMMARY) |=>
      avs_readdata_out[0]
        == $past(|(host_fault_latch_in[15:0] & host_fault_enable_in[15:0])))
    else $error("host fault lane 0 summary wrong");

  AST_GLOBAL_EXT_VENDOR: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (first_rd && reg_index == `IDX_GLOBAL_ALARM_SUMMARY) |=>
      avs_readdata_out[4] == $past(|(ext_latch_in & ext_enable_in))
      && avs_readdata_out[3]
        == $past(|(vendor_latch_in & vendor_enable_in)))
    else $error("global bits 4 and 3 wrong");

  AST_COOLING: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (first_rd && reg_index == `IDX_GENERAL_STATUS) |=>
      avs_readdata_out[13]
        == $past(cooling_overload_flag_in & interlock_used_in))
    else $error("cooling bit wrong");

  AST_SET_KEPT: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    !sys_rst_in |=> (($past(gs_set) & ~gs_latch_q) == 16'h0000))
    else $error("latched event lost");

  AST_ONE_WAIT: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    (req && waitreq_q) |=> !waitreq_q ##1 waitreq_q)
    else $error("waitrequest timing wrong");

  COV_READ_GLOBAL: cover property (@(posedge clk_in)
    accept && avs_read_in && reg_index == `IDX_GLOBAL_ALARM_SUMMARY);
  COV_FATAL: cover property (@(posedge clk_in) fatal_any);
  COV_WRITE_ENABLE: cover property (@(posedge clk_in)
    accept && avs_write_in && reg_index == `IDX_GENERAL_STATUS_ENABLE);
  COV_LATCH_CLEAR: cover property (@(posedge clk_in)
    accept && avs_read_in && reg_index == `IDX_GENERAL_STATUS_LATCH);
  COV_STATUS_FALL: cover property (@(posedge clk_in)
    $fell(|rx_signal_loss_in));

endmodule : module_fault_alarm_status_summary

// ===== testbench/host_master_model.sv
// Avalon-MM master standing in for the host management controller.
// Assumes a slave that lowers waitrequest to finish each transfer.
`timescale 1ns/1ps

module host_master_model (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        req_in,
  input  wire logic        wr_in,
  input  wire logic [15:0] index_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        avs_waitrequest_in,
  input  wire logic [31:0] avs_readdata_in,
  output logic      [17:0] avs_address_out   = 18'h00000,
  output logic             avs_read_out      = 1'b0,
  output logic             avs_write_out     = 1'b0,
  output logic      [31:0] avs_writedata_out = 32'h00000000,
  output logic      [15:0] rdata_out         = 16'h0000,
  output logic             done_out          = 1'b0
);

  // ----------------------------------------------------------
  // Bus cycle
  // ----------------------------------------------------------
  always @(posedge clk_in)
  begin
    done_out <= 1'b0;
    if (sys_rst_in)
    begin
      avs_read_out  <= 1'b0;
      avs_write_out <= 1'b0;
    end
    else if ((avs_read_out || avs_write_out) && !avs_waitrequest_in)
    begin
      avs_read_out      <= 1'b0;
      avs_write_out     <= 1'b0;
      avs_address_out   <= ~avs_address_out;
      avs_writedata_out <= ~avs_writedata_out;
      rdata_out         <= avs_readdata_in[15:0];
      done_out          <= 1'b1;
    end
    else if (req_in && !avs_read_out && !avs_write_out)
    begin
      avs_address_out   <= {index_in, 2'h0};
      avs_read_out      <= !wr_in;
      avs_write_out     <= wr_in;
      avs_writedata_out <= {16'h0000, wdata_in};
    end
  end

endmodule : host_master_model

// ===== testbench/test_module_fault_alarm_status_summary.sv
// Self-checking bench for the status and summary register group.
// Assumes the host master model and the design's constants header.
`timescale 1ns/1ps
`include "fault_summary_defs.svh"

module test_module_fault_alarm_status_summary;

  // ----------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------
  localparam logic [15:0] GA = `IDX_GLOBAL_ALARM_SUMMARY;
  localparam logic [15:0] GS = `IDX_GENERAL_STATUS;
  localparam logic [15:0] LT = `IDX_GENERAL_STATUS_LATCH;
  localparam logic [15:0] EN = `IDX_GENERAL_STATUS_ENABLE;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        req = 1'b0;
  logic        wr = 1'b0;
  logic [15:0] idx = 16'h0000;
  logic [15:0] wdat = 16'h0000;
  logic [15:0] rdat, mstate;
  logic        done, rd, wt, waitreq;
  logic [17:0] addr;
  logic [31:0] wdata, readdata;
  logic [8:0]  mstate_in = 9'h000;
  logic [255:0] aw_l = '0, aw_e = '0, nf_l = '0, nf_e = '0;
  logic [255:0] hf_l = '0, hf_e = '0;
  logic [11:0] st = 12'h000;
  logic [2:0]  ff = 3'h0;
  logic [3:0]  temp = 4'h0, vcc = 4'h0, amp = 4'h0;
  int          errors = 0, check_count = 0;
  fault_summary_pkg::word_t clat [6] = '{default: 16'h0000};
  fault_summary_pkg::word_t cen [6] = '{default: 16'h0000};
  fault_summary_pkg::word_t gexp [12] = '{16'h2000, 16'h0000,
    16'h0400, 16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0020,
    16'h0010, 16'h0008, 16'h0004, 16'h0002};
  fault_summary_pkg::word_t cexp [6] = '{16'h0080, 16'h0040,
    16'h0020, 16'h0010, 16'h0008, 16'h0001};
  fault_summary_pkg::word_t fexp [3] = '{16'h0040, 16'h0020, 16'h0002};

  module_fault_alarm_status_summary #(.NUM_LANES(16)) uut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wt),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .module_state_in(mstate_in), .state_latch_in(clat[0][8:0]),
    .state_enable_in(cen[0][8:0]),
    .net_aw2_summary_in(clat[1]), .net_aw2_enable_in(cen[1]),
    .nethost_summary_in(clat[2]), .nethost_enable_in(cen[2]),
    .ext_latch_in(clat[3]), .ext_enable_in(cen[3]),
    .vendor_latch_in(clat[4]), .vendor_enable_in(cen[4]),
    .soft_alarm_test_in(clat[5][0]),
    .net_aw_latch_in(aw_l), .net_aw_enable_in(aw_e),
    .net_fault_latch_in(nf_l), .net_fault_enable_in(nf_e),
    .host_fault_latch_in(hf_l), .host_fault_enable_in(hf_e),
    .cooling_overload_flag_in(st[0] | st[1]),
    .interlock_used_in(st[0]), .reference_clock_loss_in(st[2]),
    .tx_jitter_loop_unlock_in(st[3]),
    .tx_clock_multiplier_unlock_in(st[4]),
    .tx_functionality_loss_in({st[5], 15'h0000}),
    .tx_host_side_unlock_in({15'h0000, st[6]}),
    .rx_signal_loss_in({6'h00, st[7], 9'h000}),
    .rx_network_side_unlock_in({11'h000, st[8], 4'h0}),
    .out_of_alignment_in(st[9]), .pm_interval_done_in(st[10]),
    .high_power_active_in(st[11]), .pld_init_fault_in(ff[0]),
    .supply_fault_in(ff[1]), .checksum_fault_in(ff[2]),
    .temp_flags_in(temp), .vcc_flags_in(vcc),
    .optical_amplifier_flags_in(amp),
    .avs_readdata_out(readdata), .avs_waitrequest_out(waitreq),
    .module_state_out(mstate)
  );

  host_master_model host (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(req), .wr_in(wr),
    .index_in(idx), .wdata_in(wdat), .avs_waitrequest_in(waitreq),
    .avs_readdata_in(readdata), .avs_address_out(addr),
    .avs_read_out(rd), .avs_write_out(wt), .avs_writedata_out(wdata),
    .rdata_out(rdat), .done_out(done)
  );

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input fault_summary_pkg::word_t seen,
                       input fault_summary_pkg::word_t exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [15:0] i,
                     input logic [15:0] d);
    int n;
    @(posedge clk_in);
    req <= 1'b1;
    wr <= w;
    idx <= i;
    wdat <= d;
    @(posedge clk_in);
    req <= 1'b0;
    for (n = 0; n < 20 && done !== 1'b1; n++)
      @(posedge clk_in);
    if (done !== 1'b1)
    begin
      errors++;
      finish_test();
    end
  endtask : bus

  task automatic rchk(input logic [15:0] i,
                      input fault_summary_pkg::word_t exp);
    bus(1'b0, i, 16'h0000);
    check(rdat, exp);
  endtask : rchk

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    int i;
    check(mstate, 16'h0000);
    for (i = 16'hB018; i <= 16'hB01F; i++)
      rchk(i[15:0], 16'h0000);
    rchk(EN, 16'hA7F8);
    bus(1'b1, GS, 16'hFFFF);
    rchk(GS, 16'h0000);
    rchk(16'hB030, 16'h0000);
  endtask : t_reset

  task automatic t_global();
    int k;
    for (k = 0; k < 6; k++)
    begin
      clat[k] <= 16'h0001 << (k + 2);
      cen[k] <= 16'h0001 << (k + 2);
      rchk(GA, (k == 5) ? 16'h0000 : cexp[k]);
      clat[k] <= 16'h0001;
      cen[k] <= 16'h0002;
      rchk(GA, (k == 5) ? 16'h0001 : 16'h0000);
    end
    clat <= '{default: 16'hFFFF};
    cen <= '{default: 16'hFFFF};
    rchk(GA, 16'h00F9);
    clat <= '{default: 16'h0000};
  endtask : t_global

  task automatic t_lanes();
    int n;
    aw_l <= '1;
    nf_l <= '1;
    hf_l <= '1;
    for (n = 0; n < 16; n++)
    begin
      aw_e <= 256'h1 << (n * 16 + 15 - n);
      nf_e <= 256'h1 << (((n + 1) % 16) * 16 + n);
      hf_e <= 256'h1 << (((n + 2) % 16) * 16);
      rchk(`IDX_NET_AW1_SUMMARY, 16'h0001 << n);
      rchk(`IDX_NET_FAULT_SUMMARY, 16'h0001 << ((n + 1) % 16));
      rchk(`IDX_HOST_FAULT_SUMMARY, 16'h0001 << ((n + 2) % 16));
    end
  endtask : t_lanes

  task automatic t_status();
    int k;
    for (k = 0; k < 12; k++)
    begin
      st <= 12'h001 << k;
      rchk(GS, gexp[k]);
    end
  endtask : t_status

  task automatic t_latch();
    st <= 12'h000;
    bus(1'b0, LT, 16'h0000);
    bus(1'b0, LT, 16'h0000);
    rchk(LT, 16'h0000);
    st <= 12'h080;
    rchk(GA, 16'h0100);
    bus(1'b1, EN, 16'h0000);
    rchk(GA, 16'h0000);
    bus(1'b1, EN, 16'hFFFF);
    rchk(EN, 16'hA7FC);
    rchk(LT, 16'h0020);
    rchk(LT, 16'h0000);
    st <= 12'h000;
    rchk(LT, 16'h0020);
  endtask : t_latch

  task automatic t_fatal();
    int k;
    mstate_in <= 9'h020;
    rchk(`IDX_FATAL_FAULT_STATUS, 16'h0000);
    check(mstate, 16'h0020);
    for (k = 0; k < 3; k++)
    begin
      ff <= 3'h1 << k;
      rchk(`IDX_FATAL_FAULT_STATUS, fexp[k]);
      check(mstate, 16'h0040);
    end
    ff <= 3'h0;
    temp <= 4'h9;
    vcc <= 4'h6;
    amp <= 4'hF;
    rchk(`IDX_ALARM_WARNING_GROUP1, 16'h096F);
    temp <= 4'h6;
    vcc <= 4'h9;
    amp <= 4'h4;
    rchk(`IDX_ALARM_WARNING_GROUP1, 16'h0694);
    check(mstate, 16'h0020);
  endtask : t_fatal

  // ----------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------
  initial
  begin
    forever #10 clk_in = ~clk_in;
  end

  initial
  begin
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_global();
    t_lanes();
    t_status();
    t_latch();
    t_fatal();
    finish_test();
  end

endmodule : test_module_fault_alarm_status_summary
